// File: spr_pkg.sv
// constants for the speed-reference profile register bank
// assumes an AXI4-Lite master with 12-bit byte addresses and 32-bit data
// What this block does
// [R1] duty E low nibble at word3 bits 30-27
// [R2] second turn-on duty code at 26-19
// [R3] second turn-off duty code at 18-11
// [R4] second duty clamp code at 10-3
// [R5] hysteresis 2-bit code maps 0/0.5/1/2 percent
// [R6] first turn-off reference at word4 30-23
// [R7] first reference clamp at word4 22-15
// [R8] reference breakpoint A at word4 14-7
// [R9] breakpoint B joins word4 6-0, word5 bit30
// [R10] reference breakpoint C at word5 29-22
// [R11] reference breakpoint D at word5 21-14
// [R12] breakpoint E at word5 13-6, 5-0 reserved
// [R13] every word resets to all zeros
// [R14] word6 holds second turn-off, second clamp
// [R15] 2-bit selector picks profile type
// [R16] reads return last written value, all bits
package spr_pkg;
  localparam int unsigned SPR_ADDR_W = 12;
  localparam int unsigned SPR_NWORDS = 6;
  // register index; byte address is four times it
  localparam logic [9:0] SPR_WORD_IDX [SPR_NWORDS] =
    '{10'h094, 10'h096, 10'h098, 10'h09a, 10'h09c, 10'h09e};
  localparam logic [2:0] SPR_SLOT_W1 = 3'h0;
  localparam logic [2:0] SPR_SLOT_W2 = 3'h1;
  localparam logic [2:0] SPR_SLOT_W3 = 3'h2;
  localparam logic [2:0] SPR_SLOT_W4 = 3'h3;
  localparam logic [2:0] SPR_SLOT_W5 = 3'h4;
  localparam logic [2:0] SPR_SLOT_W6 = 3'h5;
  localparam logic [31:0] SPR_WORD_RESET = 32'h0000_0000;
  // field positions (lsb)
  localparam int unsigned SPR_PTYPE_LSB = 29;
  localparam int unsigned SPR_DUTYE_HI_LSB = 0;
  localparam int unsigned SPR_DUTYE_LO_LSB = 27;
  localparam int unsigned SPR_ON2_LSB = 19;
  localparam int unsigned SPR_OFF2_LSB = 11;
  localparam int unsigned SPR_DCLAMP2_LSB = 3;
  localparam int unsigned SPR_HYS_LSB = 1;
  localparam int unsigned SPR_ROFF1_LSB = 23;
  localparam int unsigned SPR_RCLAMP1_LSB = 15;
  localparam int unsigned SPR_REFA_LSB = 7;
  localparam int unsigned SPR_REFB_HI_LSB = 0;
  localparam int unsigned SPR_REFB_LO_BIT = 30;
  localparam int unsigned SPR_REFC_LSB = 22;
  localparam int unsigned SPR_REFD_LSB = 14;
  localparam int unsigned SPR_REFE_LSB = 6;
  localparam int unsigned SPR_ROFF2_LSB = 23;
  localparam int unsigned SPR_RCLAMP2_LSB = 15;
  // hysteresis in steps of 0.5 percent
  localparam logic [2:0] SPR_HYS_0 = 3'h0;
  localparam logic [2:0] SPR_HYS_1 = 3'h1;
  localparam logic [2:0] SPR_HYS_2 = 3'h2;
  localparam logic [2:0] SPR_HYS_3 = 3'h4;
  localparam logic [1:0] SPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPR_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SPR_PROF_EQUATION,
    SPR_PROF_LINEAR,
    SPR_PROF_STAIRCASE,
    SPR_PROF_FWD_REV
  } spr_profile_e;
endpackage : spr_pkg

// File: spr_words_if.sv
// carrier between the bus slave, the word store and the field unpacker
// assumes all users run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface spr_words_if;
  logic        we;
  logic [2:0]  slot;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [31:0] word [spr_pkg::SPR_NWORDS];
  modport host  (output we, slot, wdata, wstrb, input word);
  modport store (input we, slot, wdata, wstrb, output word);
  modport view  (input word);
endinterface : spr_words_if
`default_nettype wire

// File: spr_word_store.sv
// the six profile words as flip-flops with byte-lane writes
// assumes at most one write per cycle from the host side
`timescale 1ns/1ps
`default_nettype none
module spr_word_store (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // word access
  spr_words_if.store w
);
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction : merge

  logic [31:0] word_ff     [spr_pkg::SPR_NWORDS];
  logic [31:0] nxt_word    [spr_pkg::SPR_NWORDS];

  for (genvar g = 0; g < spr_pkg::SPR_NWORDS; g++)
  begin : g_word
    always_comb
    begin
      nxt_word[g] = word_ff[g];
      if (w.we && w.slot == 3'(g))
        nxt_word[g] = merge(word_ff[g], w.wdata, w.wstrb); // [R16]
    end
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        word_ff[g] <= spr_pkg::SPR_WORD_RESET; // [R13]
      else
        word_ff[g] <= nxt_word[g];
    end
    assign w.word[g] = word_ff[g];
  end
endmodule : spr_word_store
`default_nettype wire

// File: spr_field_unpack.sv
// splits the profile words into registered fields for the generator
// assumes words are stable except on register writes
`timescale 1ns/1ps
`default_nettype none
module spr_field_unpack (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // words
  spr_words_if.view              w,
  // fields
  output var spr_pkg::spr_profile_e profile_type,
  output logic [7:0]             duty_e,
  output logic [7:0]             second_turn_on_duty,
  output logic [7:0]             second_turn_off_duty,
  output logic [7:0]             second_duty_clamp,
  output logic [1:0]             duty_hysteresis_select,
  output logic [2:0]             hysteresis_half_pct,
  output logic [7:0]             first_turn_off_reference,
  output logic [7:0]             first_reference_clamp,
  output logic [7:0]             ref_a,
  output logic [7:0]             ref_b,
  output logic [7:0]             ref_c,
  output logic [7:0]             ref_d,
  output logic [7:0]             ref_e,
  output logic [7:0]             second_turn_off_reference,
  output logic [7:0]             second_reference_clamp
);
  function automatic logic [2:0] hys_steps(input logic [1:0] code);
    logic [2:0] r;
    unique case (code)
      2'h0: r = spr_pkg::SPR_HYS_0;
      2'h1: r = spr_pkg::SPR_HYS_1;
      2'h2: r = spr_pkg::SPR_HYS_2;
      2'h3: r = spr_pkg::SPR_HYS_3;
    endcase
    return r;
  endfunction : hys_steps

  logic [31:0] w1, w2, w3, w4, w5, w6;
  logic [1:0]  nxt_ptype;
  logic [7:0]  nxt_f [12];
  logic [1:0]  nxt_hys;
  logic [2:0]  nxt_steps;
  logic [1:0]  ptype_ff;
  logic [7:0]  f_ff [12];
  logic [1:0]  hys_ff;
  logic [2:0]  steps_ff;

  always_comb
  begin
    w1 = w.word[spr_pkg::SPR_SLOT_W1];
    w2 = w.word[spr_pkg::SPR_SLOT_W2];
    w3 = w.word[spr_pkg::SPR_SLOT_W3];
    w4 = w.word[spr_pkg::SPR_SLOT_W4];
    w5 = w.word[spr_pkg::SPR_SLOT_W5];
    w6 = w.word[spr_pkg::SPR_SLOT_W6];
    nxt_ptype = w1[spr_pkg::SPR_PTYPE_LSB +: 2]; // [R15]
    nxt_f[0] = {w2[spr_pkg::SPR_DUTYE_HI_LSB +: 4],
                w3[spr_pkg::SPR_DUTYE_LO_LSB +: 4]}; // [R1]
    nxt_f[1] = w3[spr_pkg::SPR_ON2_LSB +: 8]; // [R2]
    nxt_f[2] = w3[spr_pkg::SPR_OFF2_LSB +: 8]; // [R3]
    nxt_f[3] = w3[spr_pkg::SPR_DCLAMP2_LSB +: 8]; // [R4]
    nxt_f[4] = w4[spr_pkg::SPR_ROFF1_LSB +: 8]; // [R6]
    nxt_f[5] = w4[spr_pkg::SPR_RCLAMP1_LSB +: 8]; // [R7]
    nxt_f[6] = w4[spr_pkg::SPR_REFA_LSB +: 8]; // [R8]
    nxt_f[7] = {w4[spr_pkg::SPR_REFB_HI_LSB +: 7],
                w5[spr_pkg::SPR_REFB_LO_BIT]}; // [R9]
    nxt_f[8] = w5[spr_pkg::SPR_REFC_LSB +: 8]; // [R10]
    nxt_f[9] = w5[spr_pkg::SPR_REFD_LSB +: 8]; // [R11]
    nxt_f[10] = w5[spr_pkg::SPR_REFE_LSB +: 8]; // [R12]
    nxt_f[11] = w6[spr_pkg::SPR_ROFF2_LSB +: 8]; // [R14]
    nxt_hys = w3[spr_pkg::SPR_HYS_LSB +: 2];
    nxt_steps = hys_steps(nxt_hys); // [R5]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptype_ff <= 2'h0;
      hys_ff   <= 2'h0;
      steps_ff <= 3'h0;
      for (int i = 0; i < 12; i++)
        f_ff[i] <= 8'h00;
    end
    else
    begin
      ptype_ff <= nxt_ptype;
      hys_ff   <= nxt_hys;
      steps_ff <= nxt_steps;
      for (int i = 0; i < 12; i++)
        f_ff[i] <= nxt_f[i];
    end
  end

  logic [7:0] clamp2_ff;
  logic [7:0] nxt_clamp2;
  always_comb
    nxt_clamp2 = w6[spr_pkg::SPR_RCLAMP2_LSB +: 8]; // [R14]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clamp2_ff <= 8'h00;
    else
      clamp2_ff <= nxt_clamp2;
  end

  assign profile_type              = spr_pkg::spr_profile_e'(ptype_ff);
  assign duty_e                    = f_ff[0];
  assign second_turn_on_duty       = f_ff[1];
  assign second_turn_off_duty      = f_ff[2];
  assign second_duty_clamp         = f_ff[3];
  assign duty_hysteresis_select    = hys_ff;
  assign hysteresis_half_pct       = steps_ff;
  assign first_turn_off_reference  = f_ff[4];
  assign first_reference_clamp     = f_ff[5];
  assign ref_a                     = f_ff[6];
  assign ref_b                     = f_ff[7];
  assign ref_c                     = f_ff[8];
  assign ref_d                     = f_ff[9];
  assign ref_e                     = f_ff[10];
  assign second_turn_off_reference = f_ff[11];
  assign second_reference_clamp    = clamp2_ff;
endmodule : spr_field_unpack
`default_nettype wire

// File: spr_regs_top.sv
// speed-reference profile register bank behind an AXI4-Lite slave
// assumes one write and one read outstanding at most, single clock
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spr_regs_top (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address channel
  input  wire logic [11:0]       s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  // write data channel
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  // write response channel
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  // read address channel
  input  wire logic [11:0]       s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  // read data channel
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  // profile fields
  output var spr_pkg::spr_profile_e profile_type,
  output logic [7:0]             duty_e,
  output logic [7:0]             second_turn_on_duty,
  output logic [7:0]             second_turn_off_duty,
  output logic [7:0]             second_duty_clamp,
  output logic [1:0]             duty_hysteresis_select,
  output logic [2:0]             hysteresis_half_pct,
  output logic [7:0]             first_turn_off_reference,
  output logic [7:0]             first_reference_clamp,
  output logic [7:0]             ref_a,
  output logic [7:0]             ref_b,
  output logic [7:0]             ref_c,
  output logic [7:0]             ref_d,
  output logic [7:0]             ref_e,
  output logic [7:0]             second_turn_off_reference,
  output logic [7:0]             second_reference_clamp
);
  // returns {hit, slot} for a byte address
  function automatic logic [3:0] slot_of(input logic [11:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < spr_pkg::SPR_NWORDS; i++)
      if (a[11:2] == spr_pkg::SPR_WORD_IDX[i])
        r = {1'b1, 3'(i)};
    return r;
  endfunction : slot_of

  spr_words_if wif ();

  logic        aw_held_ff;
  logic [11:0] aw_addr_ff;
  logic        w_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        nxt_aw_held;
  logic [11:0] nxt_aw_addr;
  logic        nxt_w_held;
  logic [31:0] nxt_wdata;
  logic [3:0]  nxt_wstrb;
  logic        nxt_bvalid;
  logic [1:0]  nxt_bresp;
  logic        nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;
  logic [3:0]  wr_hit_slot;
  logic [3:0]  rd_hit_slot;
  logic        commit;
  logic        rd_take;

  always_comb
  begin
    wr_hit_slot = slot_of(aw_addr_ff);
    rd_hit_slot = slot_of(s_axil_araddr);
    commit      = aw_held_ff && w_held_ff && !bvalid_ff;
    rd_take     = s_axil_arvalid && !rvalid_ff;
  end

  assign s_axil_awready = !aw_held_ff && !bvalid_ff;
  assign s_axil_wready  = !w_held_ff && !bvalid_ff;
  assign s_axil_arready = !rvalid_ff;
  assign s_axil_bvalid  = bvalid_ff;
  assign s_axil_bresp   = bresp_ff;
  assign s_axil_rvalid  = rvalid_ff;
  assign s_axil_rdata   = rdata_ff;
  assign s_axil_rresp   = rresp_ff;

  // write goes to the store in the commit cycle
  assign wif.we    = commit && wr_hit_slot[3]; // [R16]
  assign wif.slot  = wr_hit_slot[2:0];
  assign wif.wdata = wdata_ff;
  assign wif.wstrb = wstrb_ff;

  always_comb
  begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held  = w_held_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axil_awvalid && s_axil_awready)
    begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready)
    begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axil_wdata;
      nxt_wstrb  = s_axil_wstrb;
    end
    if (commit)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit_slot[3] ? spr_pkg::SPR_RESP_OKAY
                                   : spr_pkg::SPR_RESP_SLVERR;
    end
    else if (bvalid_ff && s_axil_bready)
      nxt_bvalid = 1'b0;
    if (rd_take)
    begin
      nxt_rvalid = 1'b1;
      // unmapped reads return zero with an error
      nxt_rdata  = rd_hit_slot[3] ? wif.word[rd_hit_slot[2:0]]
                                  : 32'h0000_0000; // [R16]
      nxt_rresp  = rd_hit_slot[3] ? spr_pkg::SPR_RESP_OKAY
                                  : spr_pkg::SPR_RESP_SLVERR;
    end
    else if (rvalid_ff && s_axil_rready)
      nxt_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_held_ff  <= 1'b0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'h0;
    end
    else
    begin
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff  <= nxt_w_held;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  spr_word_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .w       (wif.store)
  );

  spr_field_unpack u_unpack (
    .aclk                      (aclk),
    .aresetn                   (aresetn),
    .w                         (wif.view),
    .profile_type              (profile_type),
    .duty_e                    (duty_e),
    .second_turn_on_duty       (second_turn_on_duty),
    .second_turn_off_duty      (second_turn_off_duty),
    .second_duty_clamp         (second_duty_clamp),
    .duty_hysteresis_select    (duty_hysteresis_select),
    .hysteresis_half_pct       (hysteresis_half_pct),
    .first_turn_off_reference  (first_turn_off_reference),
    .first_reference_clamp     (first_reference_clamp),
    .ref_a                     (ref_a),
    .ref_b                     (ref_b),
    .ref_c                     (ref_c),
    .ref_d                     (ref_d),
    .ref_e                     (ref_e),
    .second_turn_off_reference (second_turn_off_reference),
    .second_reference_clamp    (second_reference_clamp)
  );

  // checks
  logic        any_word_set;
  logic [31:0] w3, w4, w5, w6;
  always_comb
  begin
    any_word_set = 1'b0;
    for (int i = 0; i < spr_pkg::SPR_NWORDS; i++)
      any_word_set = any_word_set || (wif.word[i] != 32'h0000_0000);
    w3 = wif.word[spr_pkg::SPR_SLOT_W3];
    w4 = wif.word[spr_pkg::SPR_SLOT_W4];
    w5 = wif.word[spr_pkg::SPR_SLOT_W5];
    w6 = wif.word[spr_pkg::SPR_SLOT_W6];
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_commit_s;
    commit;
  endsequence
  sequence wr_answer_s;
    s_axil_bvalid ##0 (s_axil_bresp == $past(wr_hit_slot[3] ?
      spr_pkg::SPR_RESP_OKAY : spr_pkg::SPR_RESP_SLVERR));
  endsequence
  property write_answer_p;
    wr_commit_s |=> wr_answer_s;
  endproperty

  // bus answers and stored words
  reset_zero_a: assert property ($rose(aresetn) |-> !any_word_set) // [R13]
    else $error("profile words not zero after reset");

  write_lands_a: assert property ( // [R16]
    wif.we && wif.wstrb == 4'hf |=>
      wif.word[$past(wif.slot)] == $past(wif.wdata))
    else $error("full write not stored");

  read_echo_a: assert property ( // [R16]
    rd_take && rd_hit_slot[3] && !wif.we |=>
      s_axil_rvalid && s_axil_rdata == wif.word[$past(rd_hit_slot[2:0])])
    else $error("read data differs from stored word");

  write_answer_a: assert property (write_answer_p)
    else $error("write response missing or wrong");

  resp_hold_a: assert property (
    s_axil_bvalid && !s_axil_bready |=>
      s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped before taken");

  rdata_hold_a: assert property (
    s_axil_rvalid && !s_axil_rready |=>
      s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
    else $error("read data dropped before taken");

  busy_refuse_a: assert property (
    s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write channels open while response pending");

  read_refuse_a: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read address open while data pending");

  unmapped_rd_a: assert property (
    rd_take && !rd_hit_slot[3] |=>
      s_axil_rresp == spr_pkg::SPR_RESP_SLVERR &&
      s_axil_rdata == 32'h0000_0000)
    else $error("unmapped read not answered with error and zero");

  // fields follow the words one cycle later
  duty_e_join_a: assert property ($past(aresetn) |-> // [R1]
    duty_e == $past({wif.word[spr_pkg::SPR_SLOT_W2][3:0], w3[30:27]}))
    else $error("duty E not joined from two words");

  turn_on_a: assert property ($past(aresetn) |-> // [R2]
    second_turn_on_duty == $past(w3[26:19]))
    else $error("second turn-on duty misplaced");

  turn_off_a: assert property ($past(aresetn) |-> // [R3]
    second_turn_off_duty == $past(w3[18:11]))
    else $error("second turn-off duty misplaced");

  duty_clamp_a: assert property ($past(aresetn) |-> // [R4]
    second_duty_clamp == $past(w3[10:3]))
    else $error("second duty clamp misplaced");

  hys_map_a: assert property (w3[2:1] == 2'h3 ##1 w3[2:1] == 2'h3 |-> // [R5]
    hysteresis_half_pct == 3'h4)
    else $error("hysteresis code 3 not 2 percent");

  hys_sel_a: assert property ($past(aresetn) |-> // [R5]
    duty_hysteresis_select == $past(w3[2:1]))
    else $error("hysteresis select misplaced");

  hys_lin_a: assert property ( // [R5]
    $past(aresetn) && $past(w3[2:1]) != 2'h3 |->
      hysteresis_half_pct == {1'b0, $past(w3[2:1])})
    else $error("hysteresis codes 0 to 2 not in half steps");

  first_turn_off_reference_a: assert property ($past(aresetn) |-> // [R6]
    first_turn_off_reference == $past(w4[30:23]))
    else $error("first turn-off reference misplaced");

  first_reference_clamp_a: assert property ($past(aresetn) |-> // [R7]
    first_reference_clamp == $past(w4[22:15]))
    else $error("first reference clamp misplaced");

  ref_a_a: assert property ($past(aresetn) |-> // [R8]
    ref_a == $past(w4[14:7]))
    else $error("reference A misplaced");

  ref_b_join_a: assert property ($past(aresetn) |-> // [R9]
    ref_b == $past({w4[6:0], w5[30]}))
    else $error("reference B not joined from two words");

  ref_c_a: assert property ($past(aresetn) |-> // [R10]
    ref_c == $past(w5[29:22]))
    else $error("reference C misplaced");

  ref_d_a: assert property ($past(aresetn) |-> // [R11]
    ref_d == $past(w5[21:14]))
    else $error("reference D misplaced");

  ref_e_a: assert property ($past(aresetn) |-> // [R12]
    ref_e == $past(w5[13:6]))
    else $error("reference E misplaced");

  second_turn_off_reference_a: assert property ($past(aresetn) |-> // [R14]
    second_turn_off_reference == $past(w6[30:23]))
    else $error("second turn-off reference misplaced");

  second_reference_clamp_a: assert property ($past(aresetn) |-> // [R14]
    second_reference_clamp == $past(w6[22:15]))
    else $error("second reference clamp misplaced");

  ptype_sel_a: assert property ($past(aresetn) |-> // [R15]
    profile_type == $past(wif.word[spr_pkg::SPR_SLOT_W1][30:29]))
    else $error("profile type not from selector");
endmodule : spr_regs_top
`default_nettype wire

// File: spr_regs_top_tb_top.sv
// self-checking testbench for the speed-reference profile register bank
// assumes the bank is reached through its AXI4-Lite slave port only
`timescale 1ns/1ps
`default_nettype none
module spr_regs_top_tb_top;
  logic                  aclk      = 1'b0;
  logic                  aresetn   = 1'b0;
  logic [11:0]           awaddr    = 12'h000;
  logic                  awvalid   = 1'b0;
  logic                  awready;
  logic [31:0]           wdata     = 32'h0000_0000;
  logic [3:0]            wstrb     = 4'h0;
  logic                  wvalid    = 1'b0;
  logic                  wready;
  logic [1:0]            bresp;
  logic                  bvalid;
  logic                  bready    = 1'b0;
  logic [11:0]           araddr    = 12'h000;
  logic                  arvalid   = 1'b0;
  logic                  arready;
  logic [31:0]           rdata;
  logic [1:0]            rresp;
  logic                  rvalid;
  logic                  rready    = 1'b0;
  spr_pkg::spr_profile_e profile_type;
  logic [7:0]            f [13];
  logic [1:0]            hys_sel;
  logic [2:0]            hys_half;
  logic [31:0]           exp_w [6] = '{default: 32'h0000_0000};
  int                    error_cnt = 0;
  int                    checked   = 0;

  always #2 aclk = ~aclk;

  spr_regs_top i_spr_regs_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .profile_type(profile_type), .duty_e(f[0]),
    .second_turn_on_duty(f[1]), .second_turn_off_duty(f[2]),
    .second_duty_clamp(f[3]), .duty_hysteresis_select(hys_sel),
    .hysteresis_half_pct(hys_half), .first_turn_off_reference(f[4]),
    .first_reference_clamp(f[5]), .ref_a(f[6]), .ref_b(f[7]),
    .ref_c(f[8]), .ref_d(f[9]), .ref_e(f[10]),
    .second_turn_off_reference(f[11]), .second_reference_clamp(f[12])
  );

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask : check

  task automatic chk8(input string name, input logic [7:0] s,
                      input logic [7:0] e);
    check(name, {24'h0, s}, {24'h0, e});
  endtask : chk8

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    int n;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 50)
    begin
      error_cnt++;
      end_of_test();
    end
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 50)
    begin
      error_cnt++;
      end_of_test();
    end
    check("rdata", rdata, ed);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  function automatic logic [2:0] hys_exp(input logic [1:0] c);
    case (c)
      2'h0: hys_exp = 3'h0;
      2'h1: hys_exp = 3'h1;
      2'h2: hys_exp = 3'h2;
      default: hys_exp = 3'h4;
    endcase
  endfunction : hys_exp

  task automatic check_fields;
    check("profile_type", {30'h0, profile_type},
          {30'h0, exp_w[0][30:29]});
    chk8("duty_e", f[0], {exp_w[1][3:0], exp_w[2][30:27]});
    chk8("turn_on_duty", f[1], exp_w[2][26:19]);
    chk8("turn_off_duty", f[2], exp_w[2][18:11]);
    chk8("duty_clamp", f[3], exp_w[2][10:3]);
    chk8("hys_sel", {6'h0, hys_sel}, {6'h0, exp_w[2][2:1]});
    chk8("hys_half", {5'h0, hys_half},
         {5'h0, hys_exp(exp_w[2][2:1])});
    chk8("first_turn_off_reference", f[4], exp_w[3][30:23]);
    chk8("first_reference_clamp", f[5], exp_w[3][22:15]);
    chk8("ref_a", f[6], exp_w[3][14:7]);
    chk8("ref_b", f[7], {exp_w[3][6:0], exp_w[4][30]});
    chk8("ref_c", f[8], exp_w[4][29:22]);
    chk8("ref_d", f[9], exp_w[4][21:14]);
    chk8("ref_e", f[10], exp_w[4][13:6]);
    chk8("second_turn_off_reference", f[11], exp_w[5][30:23]);
    chk8("second_reference_clamp", f[12], exp_w[5][22:15]);
  endtask : check_fields

  // write one profile word, then let the fields settle and compare them
  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b]) exp_w[i][8*b+:8] = d[8*b+:8];
    axi_write({spr_pkg::SPR_WORD_IDX[i], 2'b00}, d, s, 2'h0);
    repeat (2) @(posedge aclk);
    check_fields();
  endtask : wr

  task automatic rd(input int i);
    axi_read({spr_pkg::SPR_WORD_IDX[i], 2'b00}, exp_w[i], 2'h0);
  endtask : rd

  task automatic t_zero_state;
    for (int i = 0; i < 6; i++)
      rd(i);
    check_fields();
  endtask : t_zero_state

  task automatic t_duty_word;
    wr(1, 32'h0000_000b, 4'hf);
    for (int c = 0; c < 4; c++)
      wr(2, {1'b1, 4'h6, 8'h3c, 8'hc3, 8'h96, 2'(c), 1'b1}, 4'hf);
    rd(2);
  endtask : t_duty_word

  task automatic t_ref_words;
    wr(3, {1'b1, 8'ha5, 8'h5a, 8'h81, 7'h55}, 4'hf);
    wr(4, {1'b1, 1'b1, 8'h7e, 8'he7, 8'h42, 6'h2b}, 4'hf);
    wr(4, {1'b0, 1'b0, 8'h81, 8'h18, 8'hbd, 6'h14}, 4'hf);
    rd(3);
    rd(4);
  endtask : t_ref_words

  task automatic t_type_and_word6;
    for (int t = 0; t < 4; t++)
      wr(0, {1'b1, 2'(t), 29'h0abc_def1}, 4'hf);
    wr(5, {1'b1, 8'hc9, 8'h36, 15'h5555}, 4'hf);
    rd(5);
    rd(0);
  endtask : t_type_and_word6

  task automatic t_strobe_and_unmapped;
    wr(3, 32'hffff_ffff, 4'h5);
    rd(3);
    axi_write(12'h254, 32'hdead_beef, 4'hf, 2'h2);
    axi_read(12'h254, 32'h0000_0000, 2'h2);
    axi_read(12'h000, 32'h0000_0000, 2'h2);
    for (int i = 0; i < 6; i++)
      rd(i);
    check_fields();
  endtask : t_strobe_and_unmapped

  task automatic t_second_reset;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    exp_w = '{default: 32'h0000_0000};
    t_zero_state();
  endtask : t_second_reset

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_zero_state();
    t_duty_word();
    t_ref_words();
    t_type_and_word6();
    t_strobe_and_unmapped();
    t_second_reset();
    end_of_test();
  end
endmodule : spr_regs_top_tb_top
`default_nettype wire
